// File: pkg/cfim_regs.vh
`ifndef CFIM_REGS_VH
`define CFIM_REGS_VH
// ****************************************
// register offsets
// ****************************************
`define CFIM_OFF_MIXER      8'h2c
`define CFIM_OFF_FEATURE    8'h2d
`define CFIM_OFF_DROPOUT    8'h2e
`define CFIM_OFF_CLK_MASK   8'h2f
`define CFIM_OFF_FLT_MASK   8'h32
`define CFIM_OFF_ANA_MASK   8'h33
`define CFIM_OFF_CLK_STATUS 8'h34
// ****************************************
// reset values
// ****************************************
`define CFIM_RST_MIXER      8'h00
`define CFIM_RST_FEATURE    8'h00
`define CFIM_RST_DROPOUT    8'hbf
`define CFIM_RST_CLK_MASK   8'hff
`define CFIM_RST_FLT_MASK   8'h00
`define CFIM_RST_ANA_MASK   8'h30
// ****************************************
// writable bits per register
// ****************************************
`define CFIM_WMASK_MIXER    8'hf0
`define CFIM_WMASK_FEATURE  8'hff
`define CFIM_WMASK_DROPOUT  8'hff
`define CFIM_WMASK_CLK      8'hc0
`define CFIM_WMASK_FLT      8'h3e
`define CFIM_WMASK_ANA      8'hf0
// ****************************************
// field positions
// ****************************************
`define CFIM_BIT_MIX_PLAY    7
`define CFIM_BIT_MIX_SIDE    6
`define CFIM_BIT_MIX_REC     5
`define CFIM_BIT_MIX_LOOP    4
`define CFIM_BIT_LIMITER     7
`define CFIM_BIT_GUARD       6
`define CFIM_BIT_THERMAL     5
`define CFIM_BIT_COMPRESSOR  4
`define CFIM_BIT_TONE1       3
`define CFIM_BIT_TONE2       2
`define CFIM_BIT_SUPPLY_SEL  1
`define CFIM_BIT_DROPOUT_ON  0
`define CFIM_BIT_CLK_ERR     7
`define CFIM_BIT_PLL_LOCK    6
`define CFIM_BIT_SHORT       5
`define CFIM_BIT_VGND        4
`define CFIM_BIT_HS_INS      3
`define CFIM_BIT_HS_REM      2
`define CFIM_BIT_HS_BTN      1
`define CFIM_BIT_ANA_UP      7
`define CFIM_BIT_ANA_LO      6
`define CFIM_BIT_VAD_UP      5
`define CFIM_BIT_VAD_DN      4
`endif

// File: src/cfim_regs.v
`timescale 1ns/1ps
// Operation
// [RQ1] mixer register bits 7..4 each enable one mixer; zero disables it
// [RQ2] feature bit 7 enables distortion limiter; resets to zero
// [RQ3] feature bit 6 enables battery protection
// [RQ4] feature bit 5 enables thermal foldback
// [RQ5] feature bit 4 enables dynamic range compressor
// [RQ6] feature bits 3 and 2 enable first and second tone generator
// [RQ7] feature bit 1 picks supply measurement: zero battery, one analog supply
// [RQ8] feature bit 0 enables brownout shutdown
// [RQ9] 8-bit dropout threshold, reset 0xbf, used when supply select is one
// [RQ10] clock mask bit 7 masks clock error interrupt; resets masked
// [RQ11] clock mask bit 6 masks pll lock interrupt; resets masked
// [RQ12] fault mask bit 5 masks output short interrupt; resets unmasked
// [RQ13] fault mask bit 4 masks driver virtual-ground interrupt
// [RQ14] fault mask bits 3..1 mask headset insert, remove, button interrupts
// [RQ15] analog mask bits 7,6 mask upper and lower threshold faults; reset zero
// [RQ16] analog mask bits 5,4 mask voice detect up and down; reset one
// [RQ17] host writes reserved bits only with their reset values
// [RQ18] latched clock error and pll lock bits set on event, clear on read
// [RQ19] masked sources never raise the interrupt; unmasked ones do
// [RQ20] reserved read-only bits read zero and ignore writes; clock mask bits 5..0 read one, their reset value
`include "cfim_regs.vh"

module cfim_regs (
  // clock and reset
  input  wire       clk_sys_i,
  input  wire       rst_b_i,
  // register port
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  output reg  [7:0] reg_rdata_o,
  // event pulses from the codec
  input  wire       ev_clk_err_i,
  input  wire       ev_pll_lock_i,
  input  wire       ev_out_short_i,
  input  wire       ev_output_driver_vgnd_i,
  input  wire       ev_hs_insert_i,
  input  wire       ev_hs_remove_i,
  input  wire       ev_hs_button_i,
  input  wire       ev_ana_upper_i,
  input  wire       ev_ana_lower_i,
  input  wire       ev_voice_activity_detector_up_i,
  input  wire       ev_voice_activity_detector_dn_i,
  // supply measurement code
  input  wire [7:0] supply_code_i,
  // mixer enables
  output reg        playback_input_mixer_on_o,
  output reg        side_chain_mixer_on_o,
  output reg        record_mixer_on_o,
  output reg        loopback_mixer_on_o,
  // feature controls
  output reg        limiter_on_o,
  output reg        battery_guard_on_o,
  output reg        thermal_foldback_on_o,
  output reg        range_compressor_on_o,
  output reg        tone_gen1_on_o,
  output reg        tone_gen2_on_o,
  output reg        supply_measure_source_o,
  output reg        dropout_shutdown_on_o,
  output reg  [7:0] dropout_threshold_value_o,
  output reg        dropout_shutdown_o,
  // interrupt request
  output reg        irq_o
);

  // ****************************************
  // register storage
  // ****************************************
  reg [7:0] mixer_reg;
  reg [7:0] feature_reg;
  reg [7:0] dropout_reg;
  reg [7:0] clk_mask_reg;
  reg [7:0] flt_mask_reg;
  reg [7:0] ana_mask_reg;
  reg [1:0] clk_status_reg;
  reg [7:0] rdata_next;
  reg       irq_next;
  reg       shut_next;
  wire      wr_mixer;
  wire      wr_feature;
  wire      wr_dropout;
  wire      wr_clk_mask;
  wire      wr_flt_mask;
  wire      wr_ana_mask;
  wire      rd_clk_status;

  // merge write data into writable bits only
  function [7:0] wmerge;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] wmask;
    begin
      wmerge = (old_val & ~wmask) | (new_val & wmask);
    end
  endfunction

  // address compare shared by all strobes
  function addr_is;
    input [7:0] addr;
    input [7:0] offset;
    begin
      addr_is = (addr == offset);
    end
  endfunction

  // ****************************************
  // strobes per offset
  // ****************************************
  // unmapped offsets raise no strobe, so their writes vanish
  assign wr_mixer      = reg_wr_i & addr_is(reg_addr_i, `CFIM_OFF_MIXER);
  assign wr_feature    = reg_wr_i & addr_is(reg_addr_i, `CFIM_OFF_FEATURE);
  assign wr_dropout    = reg_wr_i & addr_is(reg_addr_i, `CFIM_OFF_DROPOUT);
  assign wr_clk_mask   = reg_wr_i & addr_is(reg_addr_i, `CFIM_OFF_CLK_MASK);
  assign wr_flt_mask   = reg_wr_i & addr_is(reg_addr_i, `CFIM_OFF_FLT_MASK);
  assign wr_ana_mask   = reg_wr_i & addr_is(reg_addr_i, `CFIM_OFF_ANA_MASK);
  assign rd_clk_status = reg_rd_i & addr_is(reg_addr_i, `CFIM_OFF_CLK_STATUS);

  // ****************************************
  // host writable stores
  // ****************************************
  // mixer enables, low nibble read-only
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mixer_reg <= `CFIM_RST_MIXER;
    end else if (wr_mixer) begin
      mixer_reg <= wmerge(mixer_reg, reg_wdata_i, `CFIM_WMASK_MIXER); // RQ1 RQ20
    end
  end

  // feature enables, all eight bits writable
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      feature_reg <= `CFIM_RST_FEATURE;
    end else if (wr_feature) begin
      feature_reg <= reg_wdata_i; // RQ2 RQ3 RQ4 RQ5 RQ6 RQ7 RQ8
    end
  end

  // dropout threshold
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dropout_reg <= `CFIM_RST_DROPOUT;
    end else if (wr_dropout) begin
      dropout_reg <= reg_wdata_i; // RQ9
    end
  end

  // clock masks, reserved bits pinned at reset value
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_mask_reg <= `CFIM_RST_CLK_MASK;
    end else if (wr_clk_mask) begin
      clk_mask_reg <= wmerge(clk_mask_reg, reg_wdata_i, `CFIM_WMASK_CLK); // RQ10 RQ11
    end
  end

  // output fault masks, reserved bits pinned at reset value
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flt_mask_reg <= `CFIM_RST_FLT_MASK;
    end else if (wr_flt_mask) begin
      flt_mask_reg <= wmerge(flt_mask_reg, reg_wdata_i, `CFIM_WMASK_FLT); // RQ12 RQ13 RQ14
    end
  end

  // analog monitor masks, reserved bits pinned at reset value
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ana_mask_reg <= `CFIM_RST_ANA_MASK;
    end else if (wr_ana_mask) begin
      ana_mask_reg <= wmerge(ana_mask_reg, reg_wdata_i, `CFIM_WMASK_ANA); // RQ15 RQ16
    end
  end

  // ****************************************
  // latched clock status, set wins over read clear
  // ****************************************
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_status_reg <= 2'h0;
    end else begin
      if (rd_clk_status) begin
        clk_status_reg <= {ev_clk_err_i, ev_pll_lock_i}; // RQ18
      end else begin
        clk_status_reg <= clk_status_reg | {ev_clk_err_i, ev_pll_lock_i}; // RQ18
      end
    end
  end

  // read mux, unmapped reads zero
  always @* begin
    case (reg_addr_i)
      `CFIM_OFF_MIXER:      rdata_next = mixer_reg & `CFIM_WMASK_MIXER; // RQ20
      `CFIM_OFF_FEATURE:    rdata_next = feature_reg;
      `CFIM_OFF_DROPOUT:    rdata_next = dropout_reg;
      `CFIM_OFF_CLK_MASK:   rdata_next = clk_mask_reg;
      `CFIM_OFF_FLT_MASK:   rdata_next = flt_mask_reg;
      `CFIM_OFF_ANA_MASK:   rdata_next = ana_mask_reg;
      `CFIM_OFF_CLK_STATUS: rdata_next = {clk_status_reg, 6'h00}; // RQ20
      default:              rdata_next = 8'h00;
    endcase
  end

  // ****************************************
  // interrupt gating
  // ****************************************
  always @* begin
    irq_next =
      (clk_status_reg[1] & ~clk_mask_reg[`CFIM_BIT_CLK_ERR]) |               // RQ10 RQ19
      (clk_status_reg[0] & ~clk_mask_reg[`CFIM_BIT_PLL_LOCK]) |              // RQ11 RQ19
      (ev_out_short_i & ~flt_mask_reg[`CFIM_BIT_SHORT]) |                    // RQ12
      (ev_output_driver_vgnd_i & ~flt_mask_reg[`CFIM_BIT_VGND]) |            // RQ13
      (ev_hs_insert_i & ~flt_mask_reg[`CFIM_BIT_HS_INS]) |                   // RQ14
      (ev_hs_remove_i & ~flt_mask_reg[`CFIM_BIT_HS_REM]) |                   // RQ14
      (ev_hs_button_i & ~flt_mask_reg[`CFIM_BIT_HS_BTN]) |                   // RQ14
      (ev_ana_upper_i & ~ana_mask_reg[`CFIM_BIT_ANA_UP]) |                   // RQ15
      (ev_ana_lower_i & ~ana_mask_reg[`CFIM_BIT_ANA_LO]) |                   // RQ15
      (ev_voice_activity_detector_up_i & ~ana_mask_reg[`CFIM_BIT_VAD_UP]) |  // RQ16
      (ev_voice_activity_detector_dn_i & ~ana_mask_reg[`CFIM_BIT_VAD_DN]);   // RQ16
  end

  // dropout decision on analog supply source only
  always @* begin
    shut_next = feature_reg[`CFIM_BIT_DROPOUT_ON] &
                feature_reg[`CFIM_BIT_SUPPLY_SEL] &
                (supply_code_i < dropout_reg); // RQ8 RQ9
  end

  // ****************************************
  // registered host outputs
  // ****************************************
  // read data follows the address every cycle, one cycle late
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= rdata_next;
    end
  end

  // interrupt level, flopped so no decode glitch reaches the pin
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_next; // RQ19
    end
  end

  // ****************************************
  // registered control outputs
  // ****************************************
  // mixer enables
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      playback_input_mixer_on_o <= 1'b0;
      side_chain_mixer_on_o     <= 1'b0;
      record_mixer_on_o         <= 1'b0;
      loopback_mixer_on_o       <= 1'b0;
    end else begin
      playback_input_mixer_on_o <= mixer_reg[`CFIM_BIT_MIX_PLAY]; // RQ1
      side_chain_mixer_on_o     <= mixer_reg[`CFIM_BIT_MIX_SIDE]; // RQ1
      record_mixer_on_o         <= mixer_reg[`CFIM_BIT_MIX_REC]; // RQ1
      loopback_mixer_on_o       <= mixer_reg[`CFIM_BIT_MIX_LOOP]; // RQ1
    end
  end

  // protection and generator enables
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      limiter_on_o              <= 1'b0;
      battery_guard_on_o        <= 1'b0;
      thermal_foldback_on_o     <= 1'b0;
      range_compressor_on_o     <= 1'b0;
      tone_gen1_on_o            <= 1'b0;
      tone_gen2_on_o            <= 1'b0;
      supply_measure_source_o   <= 1'b0;
      dropout_shutdown_on_o     <= 1'b0;
    end else begin
      limiter_on_o              <= feature_reg[`CFIM_BIT_LIMITER]; // RQ2
      battery_guard_on_o        <= feature_reg[`CFIM_BIT_GUARD]; // RQ3
      thermal_foldback_on_o     <= feature_reg[`CFIM_BIT_THERMAL]; // RQ4
      range_compressor_on_o     <= feature_reg[`CFIM_BIT_COMPRESSOR]; // RQ5
      tone_gen1_on_o            <= feature_reg[`CFIM_BIT_TONE1]; // RQ6
      tone_gen2_on_o            <= feature_reg[`CFIM_BIT_TONE2]; // RQ6
      supply_measure_source_o   <= feature_reg[`CFIM_BIT_SUPPLY_SEL]; // RQ7
      dropout_shutdown_on_o     <= feature_reg[`CFIM_BIT_DROPOUT_ON]; // RQ8
    end
  end

  // threshold copy resets with its store, so no step at release
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dropout_threshold_value_o <= `CFIM_RST_DROPOUT;
    end else begin
      dropout_threshold_value_o <= dropout_reg; // RQ9
    end
  end

  // shutdown request, one cycle behind the supply code
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dropout_shutdown_o <= 1'b0;
    end else begin
      dropout_shutdown_o <= shut_next; // RQ9
    end
  end

endmodule

// File: test/cfim_regs_monitor.sv
`timescale 1ns/1ps
module cfim_regs_monitor (
  input wire       clk_sys_i, rst_b_i, reg_wr_i, reg_rd_i, ev_clk_err_i, irq_o,
  input wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, supply_code_i,
  input wire [7:0] dropout_threshold_value_o,
  input wire       playback_input_mixer_on_o, side_chain_mixer_on_o, record_mixer_on_o,
  input wire       loopback_mixer_on_o, limiter_on_o, battery_guard_on_o,
  input wire       thermal_foldback_on_o, range_compressor_on_o, tone_gen1_on_o,
  input wire       tone_gen2_on_o, supply_measure_source_o, dropout_shutdown_on_o,
  input wire       dropout_shutdown_o
);
  // packed views of the enable outputs
  wire [7:0] mix = {playback_input_mixer_on_o, side_chain_mixer_on_o, record_mixer_on_o,
                    loopback_mixer_on_o, 4'h0};
  wire [7:0] feat = {limiter_on_o, battery_guard_on_o, thermal_foldback_on_o,
                     range_compressor_on_o, tone_gen1_on_o, tone_gen2_on_o,
                     supply_measure_source_o, dropout_shutdown_on_o};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  AST_RST_VAL:
    assert property ($rose(rst_b_i) |-> dropout_threshold_value_o == 8'hbf && feat == 8'h00)
    else $error("bad value after reset");
  AST_MIX_WR:
    assert property (reg_wr_i && reg_addr_i == 8'h2c |=> ##1
      mix == ($past(reg_wdata_i, 2) & 8'hf0)) else $error("mixer enables wrong");
  AST_FEAT_WR:
    assert property (reg_wr_i && reg_addr_i == 8'h2d |=> ##1 feat == $past(reg_wdata_i, 2))
    else $error("feature enables wrong");
  AST_THR_WR:
    assert property (reg_wr_i && reg_addr_i == 8'h2e |=> ##1
      dropout_threshold_value_o == $past(reg_wdata_i, 2)) else $error("threshold wrong");
  AST_DROPOUT:
    assert property (dropout_shutdown_o == (dropout_shutdown_on_o && supply_measure_source_o
      && $past(supply_code_i) < dropout_threshold_value_o)) else $error("dropout wrong");
  AST_LATCH_SET:
    assert property (ev_clk_err_i ##1 reg_addr_i == 8'h34 |=> reg_rdata_o[7])
    else $error("clock error not latched");
  AST_LATCH_CLR:
    assert property (reg_rd_i && reg_addr_i == 8'h34 && !ev_clk_err_i ##1
      reg_addr_i == 8'h34 |=> !reg_rdata_o[7]) else $error("status not cleared");
  AST_UNMAPPED:
    assert property (!(reg_addr_i inside {8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h32, 8'h33, 8'h34})
      |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  AST_MIX_RSVD:
    assert property (reg_addr_i == 8'h2c |=> reg_rdata_o[3:0] == 4'h0)
    else $error("reserved mixer bits not zero");
  cover property (reg_wr_i && reg_addr_i == 8'h2d);
  cover property (dropout_shutdown_o);
  cover property ($rose(irq_o));
endmodule
bind cfim_regs cfim_regs_monitor cfim_regs_monitor_i (.*);

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk_sys_i, rst_b_i, reg_wr_i, reg_rd_i, dsd, irq;
  logic [7:0]  reg_addr_i, reg_wdata_i, supply_code_i, rdata, thr, feat, m [8];
  logic [3:0]  mix;
  logic [10:0] ev;
  logic [31:0] seed = 32'hf20bf086;
  int          n_mismatch, checked, i, k, r;
  logic [7:0]  adr [8] = '{8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h32, 8'h33, 8'h34, 8'h40};
  logic [7:0]  rv [8] = '{8'h00, 8'h00, 8'hbf, 8'hff, 8'h00, 8'h30, 8'h00, 8'h00};
  logic [7:0]  wm [8] = '{8'hf0, 8'hff, 8'hff, 8'hc0, 8'h3e, 8'hf0, 8'h00, 8'h00};
  int          mr [11] = '{3, 3, 4, 4, 4, 4, 4, 5, 5, 5, 5};
  int          mb [11] = '{7, 6, 5, 4, 3, 2, 1, 7, 6, 5, 4};
  cfim_regs cfim_regs_i (.clk_sys_i, .rst_b_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o(rdata), .supply_code_i, .ev_clk_err_i(ev[0]),
    .ev_pll_lock_i(ev[1]), .ev_out_short_i(ev[2]), .ev_output_driver_vgnd_i(ev[3]),
    .ev_hs_insert_i(ev[4]), .ev_hs_remove_i(ev[5]), .ev_hs_button_i(ev[6]),
    .ev_ana_upper_i(ev[7]), .ev_ana_lower_i(ev[8]),
    .ev_voice_activity_detector_up_i(ev[9]), .ev_voice_activity_detector_dn_i(ev[10]),
    .playback_input_mixer_on_o(mix[3]), .side_chain_mixer_on_o(mix[2]),
    .record_mixer_on_o(mix[1]), .loopback_mixer_on_o(mix[0]), .limiter_on_o(feat[7]),
    .battery_guard_on_o(feat[6]), .thermal_foldback_on_o(feat[5]),
    .range_compressor_on_o(feat[4]), .tone_gen1_on_o(feat[3]), .tone_gen2_on_o(feat[2]),
    .supply_measure_source_o(feat[1]), .dropout_shutdown_on_o(feat[0]),
    .dropout_threshold_value_o(thr), .dropout_shutdown_o(dsd), .irq_o(irq));
  // ***
  // helpers
  // ***
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(string s, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // one write strobe; model keeps only the writable bits
  task wr(int j, logic [7:0] d);
    reg_addr_i = adr[j];
    reg_wdata_i = d;
    reg_wr_i = 1;
    @(negedge clk_sys_i);
    reg_wr_i = 0;
    m[j] = (d & wm[j]) | (rv[j] & ~wm[j]);
  endtask
  task rd(int j);
    reg_addr_i = adr[j];
    reg_rd_i = 1;
    @(negedge clk_sys_i);
    reg_rd_i = 0;
    chk("rdata", rdata, m[j]);
    if (j == 6) m[6] = 8'h00;
  endtask
  task complete_run();
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk_sys_i = 0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  // ***
  // main sequence
  // ***
  initial begin
    {rst_b_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, supply_code_i, ev} = '0;
    for (i = 0; i < 8; i++) m[i] = rv[i];
    repeat (6) @(negedge clk_sys_i);
    rst_b_i = 1;
    for (i = 0; i < 8; i++) rd(i);
    wr(0, 8'hff);
    rd(0);
    for (k = 0; k < 80; k++) begin
      r = xs() % 8;
      supply_code_i = xs();
      wr(r, (xs() & wm[r]) | (rv[r] & ~wm[r]));
      rd(r);
      chk("mixer", {mix, 4'h0}, m[0] & 8'hf0);
      chk("feature", feat, m[1]);
      chk("threshold", thr, m[2]);
      chk("dropout", dsd, m[1][0] & m[1][1] & (supply_code_i < m[2]));
    end
    wr(3, 8'hff);
    wr(4, 8'h3e);
    wr(5, 8'hf0);
    // each source pulsed once unmasked and once masked
    for (i = 0; i < 11; i++) for (k = 0; k < 2; k++) begin
      wr(mr[i], k ? m[mr[i]] : m[mr[i]] & ~(8'h01 << mb[i]));
      ev[i] = 1;
      @(negedge clk_sys_i);
      ev[i] = 0;
      if (i > 1) chk("irq", irq, !k);
      @(negedge clk_sys_i);
      if (i < 2) begin
        chk("irq", irq, !k);
        m[6] = 8'h80 >> i;
        rd(6);
        rd(6);
      end
      wr(mr[i], m[mr[i]] | (8'h01 << mb[i]));
    end
    complete_run();
  end
endmodule
